// ### rtl/scch_regs.svh
// Constants of the serial configuration command handler.
// Assumes inclusion by bare name from the design files.
`ifndef SCCH_REGS_SVH
`define SCCH_REGS_SVH
// Command numbers
`define SCCH_CMD_RESET 8'h00
`define SCCH_CMD_GETERR 8'h42
`define SCCH_CMD_NORM 8'h46
`define SCCH_CMD_SETTX 8'h80
`define SCCH_CMD_GETTX 8'h81
`define SCCH_CMD_WRITE_BITRATE_CODE 8'h82
`define SCCH_CMD_READ_BITRATE_CODE 8'h83
`define SCCH_CMD_SETSLOW 8'h86
`define SCCH_CMD_GETSLOW 8'h87
`define SCCH_CMD_SETSPEC 8'h88
`define SCCH_CMD_GETSPEC 8'h89
`define SCCH_CMD_SETRATE 8'h8a
`define SCCH_CMD_GETRATE 8'h8b
// Result codes
`define SCCH_ERR_CLEAR 8'h00
`define SCCH_ERR_OK 8'ha0
`define SCCH_ERR_OKX 8'ha1
`define SCCH_ERR_NOCMD 8'h40
`define SCCH_ERR_BITS 8'h53
`define SCCH_ERR_BIG 8'h54
`define SCCH_ERR_SMALL 8'h55
`define SCCH_ERR_RELBIG 8'h58
`define SCCH_ERR_BLOCK 8'h71
`define SCCH_ERR_NOJMP 8'h73
// Field positions
`define SCCH_TX_HS 7
`define SCCH_TX_LONG 3
`define SCCH_SP_SLOW 0
`define SCCH_SP_FIR 2
`define SCCH_SP_SEL 3
`define SCCH_SP_AUTOF 4
`define SCCH_SP_ABS 10
`define SCCH_SP_WMASK 16'hc73d
// Reset values
`define SCCH_TX_RST 8'h08
`define SCCH_BAUD_RST 8'h03
`define SCCH_SLOW_RST 16'h0001
`define SCCH_SPEC_RST 16'h0010
`define SCCH_AVG_RST 6'h01
`define SCCH_RATE_RST 16'h0014
// Limits, frames, timing
`define SCCH_AVG_MAX 6'h0b
`define SCCH_BAUD_MAX 8'h0b
`define SCCH_BAUD_CFG 4'h3
`define SCCH_SHORT_PFX 8'ha5
`define SCCH_LONG_PFX 8'ha6
`define SCCH_SHORT_LEN 3'h3
`define SCCH_LONG_LEN 3'h5
`define SCCH_PF_LO_X100 1428
`define SCCH_PF_MID 1250
`define SCCH_PF_LO_FIR 30
`define SCCH_PF_MID_FIR 2142
`define SCCH_CLK_NS 20
`define SCCH_SEC_NS 1000000000
`endif

// ### rtl/scch_pkg.sv
// Types of the serial configuration command handler.
// Assumes scch_regs.svh for numeric constants.
package scch_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_PARAM = 2'h1, ST_EXEC = 2'h2, ST_SEND = 2'h3
  } scch_state_t;
  typedef struct packed {
    scch_state_t st;
    logic [7:0] cmd, err, txf, baud, tx_d;
    logic [1:0] need, pf;
    logic [23:0] par;
    logic [39:0] obuf;
    logic [2:0] cnt, jp_s, wb_s, cts_s;
    logic jp, wb, cts, pend, rx_rdy, rts_n, tx_v, norm;
    logic [15:0] slow, spec, rate, peak, last, secs;
    logic [5:0] avg;
    logic [25:0] sub;
    logic [3:0] bsel;
  } scch_core_t;
endpackage : scch_pkg

// ### rtl/scch_top.sv
// Command handler and its output FIFO.
// Assumes byte streams from/to a UART on clk; pins are asynchronous.
`include "scch_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module scch_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] cnt;
    logic [AW-1:0] rd;
  } scch_fifo_t;
  scch_fifo_t q, d;
  logic push, pop;
  logic [AW-1:0] wr;

  always_comb begin
    in_ready = q.cnt != (AW+1)'(D);
    out_valid = q.cnt != '0;
    out_data = q.mem[q.rd];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr = q.rd + q.cnt[AW-1:0];
    d = q;
    if (push) begin
      d.mem[wr] = in_data;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (sys_rst) begin
      d.cnt = '0;
      d.rd = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end
endmodule : scch_fifo

// Summary of operation
// - Command 70 starts scale calculation; channel 0, gain one, micro-strain.
// - Protocol-mode write 128 accepted only with configuration jumper fitted.
// - Protocol bit 3 picks five-byte (set) or three-byte measurement frame.
// - Short frame: prefix byte then 16-bit value, high byte first.
// - Protocol bit 7 enables RTS/CTS flow control where hardware supports it.
// - Command 129 returns handshake, frame length, write-block, jumper bits.
// - Write-block flag reads zero with write access, one when blocked.
// - Command 130 takes bitrate code 0 to 11.
// - Bitrate changes only with jumper; host follows power-cycle procedure.
// - Jumper fitted forces 38400 bit/s; stored code applies once removed.
// - Bitrate change refused when output data rate is too high.
// - Command 131 returns bitrate code as one byte.
// - Command 134 takes two-byte slow period, high first, 1 to 65535.
// - Command 135 returns slow period as two bytes.
// - Feature bit 8 commits changes at once; bit 9 selects English.
// - Feature bit 10 in maximum mode sends peak of absolute value.
// - Feature bit 1 reads averaging count above one; bit 2 enables FIR.
// - Feature bit 0 sends at slow period, ignoring other rates.
// - Selective bit in maximum mode sends only new maxima.
// - Auto prefilter picks low, middle or high band from data rate.
// - FIR order bit: second order when clear, fifth order when set.
// - Command 138 takes averaging count then rate high, low; count 1-11.
// - Every command but last-error query overwrites the error register.
// - Refusal for missing jumper leaves access-denied code.
module scch_top #(
  parameter int unsigned SLOW_UNIT_CYC = `SCCH_SEC_NS / `SCCH_CLK_NS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic cts_n_pin,
  output logic rts_n,
  input wire logic config_jumper,
  input wire logic write_block_pin,
  input wire logic meas_valid,
  input wire logic [15:0] meas_value,
  input wire logic max_mode,
  output logic norm_start,
  output logic [3:0] link_bitrate_code,
  output logic [7:0] protocol_flags,
  output logic [15:0] feature_flags,
  output logic [5:0] conv_avg_count,
  output logic [15:0] conv_rate,
  output logic [1:0] prefilter_sel
);
  import scch_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] nparams(input logic [7:0] c);
    case (c)
      `SCCH_CMD_SETTX, `SCCH_CMD_WRITE_BITRATE_CODE: nparams = 2'h1;
      `SCCH_CMD_SETSLOW, `SCCH_CMD_SETSPEC: nparams = 2'h2;
      `SCCH_CMD_SETRATE: nparams = 2'h3;
      default: nparams = 2'h0;
    endcase
  endfunction : nparams

  function automatic logic [31:0] baud_bps(input logic [3:0] c);
    case (c)
      4'h0: baud_bps = 32'h000012c0;
      4'h1: baud_bps = 32'h00002580;
      4'h2: baud_bps = 32'h00004b00;
      4'h3: baud_bps = 32'h00009600;
      4'h4: baud_bps = 32'h0000e100;
      4'h5: baud_bps = 32'h0001c200;
      4'h6: baud_bps = 32'h0003d090;
      4'h7: baud_bps = 32'h00098968;
      4'h8: baud_bps = 32'h001312d0;
      4'h9: baud_bps = 32'h00038400;
      4'ha: baud_bps = 32'h00070800;
      default: baud_bps = 32'h000e1000;
    endcase
  endfunction : baud_bps

  // ----------------------------------------
  // State
  // ----------------------------------------
  scch_core_t q, d;
  logic acc, launch, room, f_in_ready, f_out_valid, f_pop;
  logic [7:0] f_out_data;
  logic signed [15:0] v;
  logic newmax, long_f, cts_ok, wdone;
  logic [31:0] r32, c32, need_bps;

  scch_fifo #(.W(8), .D(16)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(q.st == ST_SEND),
    .in_data(q.obuf[39:32]),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_pop)
  );

  always_comb begin
    d = q;
    d.norm = 1'b0;
    // Level is adopted from the third flop when second and third agree; first flop is read only by the second
    d.jp_s = {q.jp_s[1:0], config_jumper};
    d.wb_s = {q.wb_s[1:0], write_block_pin};
    d.cts_s = {q.cts_s[1:0], ~cts_n_pin};
    if (q.jp_s[1] == q.jp_s[2]) d.jp = q.jp_s[2];
    if (q.wb_s[1] == q.wb_s[2]) d.wb = q.wb_s[2];
    if (q.cts_s[1] == q.cts_s[2]) d.cts = q.cts_s[2];
    long_f = q.txf[`SCCH_TX_LONG];
    acc = rx_valid && q.rx_rdy;
    room = f_in_ready;
    wdone = 1'b0;
    launch = (q.st == ST_IDLE) && !acc && q.pend && room;
    r32 = 32'(q.rate);
    c32 = 32'(q.avg);
    need_bps = 32'(q.rate) * (long_f ? 32'h5 : 32'h3) * 32'h5;

    // ----------------------------------------
    // Measurement selection
    // ----------------------------------------
    v = $signed(meas_value);
    if (q.spec[`SCCH_SP_ABS] && max_mode && v < 0) v = -v;
    newmax = max_mode && (v > $signed(q.peak));
    if (meas_valid && newmax) d.peak = v;
    if (launch) d.pend = 1'b0;
    if (meas_valid) begin
      d.last = (max_mode && !newmax) ? q.peak : v;
      if (!q.spec[`SCCH_SP_SLOW] && (!(q.spec[`SCCH_SP_SEL] && max_mode)
          || newmax)) begin
        d.pend = 1'b1;
      end
    end
    // Slow mode: whole seconds counted, other rates ignored
    d.sub = q.sub + 26'h1;
    if (q.sub == 26'(SLOW_UNIT_CYC - 1)) begin
      d.sub = '0;
      d.secs = q.secs + 16'h1;
      if (q.secs + 16'h1 >= q.slow) begin
        d.secs = '0;
        if (q.spec[`SCCH_SP_SLOW]) d.pend = 1'b1;
      end
    end

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    case (q.st)
      ST_IDLE: begin
        if (acc) begin
          d.cmd = rx_data;
          d.need = nparams(rx_data);
          d.st = (nparams(rx_data) == 2'h0) ? ST_EXEC : ST_PARAM;
        end else if (launch) begin
          d.st = ST_SEND;
          if (long_f) begin
            d.obuf = {`SCCH_LONG_PFX, {16{q.last[15]}}, q.last};
            d.cnt = `SCCH_LONG_LEN;
          end else begin
            d.obuf = {`SCCH_SHORT_PFX, q.last, 16'h0};
            d.cnt = `SCCH_SHORT_LEN;
          end
        end
      end
      ST_PARAM: begin
        if (acc) begin
          d.par = {q.par[15:0], rx_data};
          d.need = q.need - 2'h1;
          if (q.need == 2'h1) d.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        d.cnt = 3'h0;
        d.err = `SCCH_ERR_OK;
        wdone = 1'b0;
        case (q.cmd)
          `SCCH_CMD_RESET: d.err = `SCCH_ERR_CLEAR;
          `SCCH_CMD_GETERR: begin
            d.err = q.err;
            d.obuf = {q.err, 32'h0};
            d.cnt = 3'h1;
          end
          `SCCH_CMD_NORM: begin
            if (q.wb) d.err = `SCCH_ERR_BLOCK;
            else begin
              d.norm = 1'b1;
              d.err = `SCCH_ERR_OKX;
            end
          end
          `SCCH_CMD_SETTX: begin
            if (q.wb) d.err = `SCCH_ERR_BLOCK;
            else if (!q.jp) d.err = `SCCH_ERR_NOJMP;
            else d.txf = q.par[7:0] & 8'h88;
          end
          `SCCH_CMD_GETTX: begin
            d.obuf = {q.txf[7], 2'h0, q.wb, q.txf[3], 2'h0, q.jp,
                      32'h0};
            d.cnt = 3'h1;
          end
          `SCCH_CMD_WRITE_BITRATE_CODE: begin
            if (q.wb) d.err = `SCCH_ERR_BLOCK;
            else if (!q.jp) d.err = `SCCH_ERR_NOJMP;
            else if (q.par[7:0] > `SCCH_BAUD_MAX) d.err = `SCCH_ERR_BIG;
            else if (need_bps > baud_bps(q.par[3:0]) * c32) begin
              d.err = `SCCH_ERR_RELBIG;
            end else d.baud = q.par[7:0];
          end
          `SCCH_CMD_READ_BITRATE_CODE: begin
            d.obuf = {q.baud, 32'h0};
            d.cnt = 3'h1;
          end
          `SCCH_CMD_SETSLOW: begin
            if (q.wb) d.err = `SCCH_ERR_BLOCK;
            else if (q.par[15:0] == 16'h0) d.err = `SCCH_ERR_SMALL;
            else d.slow = q.par[15:0];
          end
          `SCCH_CMD_GETSLOW: begin
            d.obuf = {q.slow, 24'h0};
            d.cnt = 3'h2;
          end
          `SCCH_CMD_SETSPEC: begin
            if (q.wb) d.err = `SCCH_ERR_BLOCK;
            else d.spec = (q.par[15:0] & `SCCH_SP_WMASK) |
                          (q.spec & ~`SCCH_SP_WMASK);
          end
          `SCCH_CMD_GETSPEC: begin
            d.obuf = {q.spec[15:2], q.avg > 6'h1, q.spec[0], 24'h0};
            d.cnt = 3'h2;
          end
          `SCCH_CMD_SETRATE: begin
            if (q.wb) d.err = `SCCH_ERR_BLOCK;
            else if (q.par[23:22] != 2'h3) d.err = `SCCH_ERR_BITS;
            else if (q.par[21:16] == 6'h0) d.err = `SCCH_ERR_SMALL;
            else if (q.par[21:16] > `SCCH_AVG_MAX) d.err = `SCCH_ERR_BIG;
            else wdone = 1'b1;
            if (wdone) begin
              d.avg = q.par[21:16];
              d.rate = q.par[15:0];
            end
          end
          `SCCH_CMD_GETRATE: begin
            d.obuf = {2'h3, q.avg, q.rate, 16'h0};
            d.cnt = 3'h3;
          end
          default: d.err = `SCCH_ERR_NOCMD;
        endcase
        d.st = (d.cnt == 3'h0) ? ST_IDLE : ST_SEND;
      end
      ST_SEND: begin
        if (room) begin
          d.obuf = {q.obuf[31:0], 8'h0};
          d.cnt = q.cnt - 3'h1;
          if (q.cnt == 3'h1) d.st = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    // ----------------------------------------
    // Link side and derived settings
    // ----------------------------------------
    // Flow control stalls the drain, so the FIFO fills and stalls the host
    cts_ok = !q.txf[`SCCH_TX_HS] || q.cts;
    f_pop = !q.tx_v || (tx_ready && cts_ok);
    if (f_pop) begin
      d.tx_v = f_out_valid;
      d.tx_d = f_out_data;
    end
    d.rx_rdy = (d.st == ST_IDLE) || (d.st == ST_PARAM);
    d.rts_n = q.txf[`SCCH_TX_HS] ? !d.rx_rdy : 1'b0;
    d.bsel = q.jp ? `SCCH_BAUD_CFG : q.baud[3:0];
    if (q.spec[`SCCH_SP_AUTOF]) begin
      if (q.spec[`SCCH_SP_FIR]) begin
        d.pf = (r32 <= `SCCH_PF_LO_FIR * c32) ? 2'h0 :
               (r32 < `SCCH_PF_MID_FIR * c32) ? 2'h1 : 2'h2;
      end else begin
        d.pf = (r32 * 100 <= `SCCH_PF_LO_X100 * c32) ? 2'h0 :
               (r32 < `SCCH_PF_MID * c32) ? 2'h1 : 2'h2;
      end
    end
    if (sys_rst) begin
      d = '0;
      d.rts_n = 1'b1;
      d.txf = `SCCH_TX_RST;
      d.baud = `SCCH_BAUD_RST;
      d.bsel = `SCCH_BAUD_CFG;
      d.slow = `SCCH_SLOW_RST;
      d.spec = `SCCH_SPEC_RST;
      d.avg = `SCCH_AVG_RST;
      d.rate = `SCCH_RATE_RST;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign rx_ready = q.rx_rdy;
  assign tx_valid = q.tx_v;
  assign tx_data = q.tx_d;
  assign rts_n = q.rts_n;
  assign norm_start = q.norm;
  assign link_bitrate_code = q.bsel;
  assign protocol_flags = q.txf;
  assign feature_flags = q.spec;
  assign conv_avg_count = q.avg;
  assign conv_rate = q.rate;
  assign prefilter_sel = q.pf;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_exec(logic [7:0] c);
    q.st == ST_EXEC && q.cmd == c;
  endsequence
  sequence s_take(logic [7:0] c);
    q.st == ST_IDLE && acc && rx_data == c;
  endsequence

  a_norm_pulse: assert property (
    s_exec(`SCCH_CMD_NORM) ##0 !q.wb |=> norm_start && q.err == 8'ha1
  ) else $error("calc norm did not pulse");
  a_txmode_jumper: assert property (
    s_exec(`SCCH_CMD_SETTX) ##0 (!q.wb && !q.jp)
      |=> q.err == 8'h73 && $stable(q.txf)
  ) else $error("protocol write taken without jumper");
  a_short_frame: assert property (
    launch && !q.txf[3] |=> q.obuf[39:32] == 8'ha5 && q.cnt == 3'h3
  ) else $error("short frame malformed");
  a_cfg_bitrate: assert property (
    q.jp |=> link_bitrate_code == 4'h3
  ) else $error("jumper did not force 38400");
  a_baud_range: assert property (
    s_exec(`SCCH_CMD_WRITE_BITRATE_CODE) ##0 (!q.wb && q.jp && q.par[7:0] > 8'h0b)
      |=> q.err == 8'h54 && $stable(q.baud)
  ) else $error("bad bitrate code accepted");
  a_err_keep: assert property (
    s_exec(`SCCH_CMD_GETERR) |=> $stable(q.err)
  ) else $error("error query changed error");
  a_slow_zero: assert property (
    s_exec(`SCCH_CMD_SETSLOW) ##0 (!q.wb && q.par[15:0] == 16'h0)
      |=> q.err == 8'h55 && q.slow != 16'h0
  ) else $error("zero slow period accepted");
  a_read_bitrate: assert property (
    s_take(`SCCH_CMD_READ_BITRATE_CODE) |=> ##1
      q.st == ST_SEND && q.cnt == 3'h1 && q.obuf[39:32] == q.baud
  ) else $error("bitrate read reply wrong");
  a_txmode_read: assert property (
    s_take(`SCCH_CMD_GETTX) |=> ##1
      q.obuf[32] == $past(q.jp) && q.obuf[36] == $past(q.wb)
  ) else $error("protocol flag read wrong");
  a_rate_count: assert property (
    s_exec(`SCCH_CMD_SETRATE) ##0 (!q.wb && q.par[23:22] == 2'h3
      && q.par[21:16] > 6'h0b) |=> q.err == 8'h54 && q.avg <= 6'h0b
  ) else $error("averaging count above limit");
endmodule : scch_top
`default_nettype wire

// ### tb/scch_host.sv
// Host model: sends command bytes and takes reply bytes.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module scch_host (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic cts_n_pin
);
  int n_late = 0;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    cts_n_pin = 1'b0;
  end

  // ------------------------------------------------------------
  // Byte transfers
  // ------------------------------------------------------------
  // Held until taken; released data shows the inverse, not a stale byte
  task automatic send_byte(input logic [7:0] b);
    int k;
    rx_valid = 1'b1;
    rx_data = b;
    k = 0;
    while (rx_ready !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 2000) n_late++;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_data = ~b;
    // One idle edge, so a following byte never re-raises valid at once
    @(posedge clk);
    #1;
  endtask : send_byte

  // Stall lets the device queue up before the host takes anything
  task automatic recv_byte(input int stall, output logic [7:0] b);
    int k;
    repeat (stall) begin
      @(posedge clk);
      #1;
    end
    tx_ready = 1'b1;
    k = 0;
    while (tx_valid !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 2000) n_late++;
    b = tx_data;
    @(posedge clk);
    #1;
    tx_ready = 1'b0;
    @(posedge clk);
    #1;
  endtask : recv_byte

  // Ready offered for n edges; a byte may leave only if flow control allows
  task automatic hold_ready(input int n);
    tx_ready = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    tx_ready = 1'b0;
    @(posedge clk);
    #1;
  endtask : hold_ready

  task automatic set_cts_n(input logic v);
    cts_n_pin = v;
  endtask : set_cts_n
endmodule : scch_host

`default_nettype wire

// ### tb/scch_top_bench.sv
// Self-checking bench for the command handler.
// Assumes scch_host drives the byte side; measurements come from here.
`timescale 1ns/1ps
`default_nettype none

module scch_top_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rx_valid, rx_ready, tx_valid, tx_ready, cts_n_pin, rts_n;
  logic [7:0] rx_data, tx_data, protocol_flags;
  logic config_jumper = 1'b0;
  logic write_block_pin = 1'b0;
  logic meas_valid = 1'b0;
  logic [15:0] meas_value = 16'h0000;
  logic max_mode = 1'b0;
  logic norm_start;
  logic [3:0] link_bitrate_code;
  logic [15:0] feature_flags, conv_rate;
  logic [5:0] conv_avg_count;
  logic [1:0] prefilter_sel;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_norm = 0;

  always #10 clk = ~clk;

  // Counted mid-cycle, where the pulse has settled
  always @(negedge clk) if (norm_start === 1'b1) n_norm++;

  scch_top #(.SLOW_UNIT_CYC(20)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .cts_n_pin(cts_n_pin), .rts_n(rts_n),
    .config_jumper(config_jumper), .write_block_pin(write_block_pin),
    .meas_valid(meas_valid), .meas_value(meas_value), .max_mode(max_mode),
    .norm_start(norm_start), .link_bitrate_code(link_bitrate_code),
    .protocol_flags(protocol_flags), .feature_flags(feature_flags),
    .conv_avg_count(conv_avg_count), .conv_rate(conv_rate),
    .prefilter_sel(prefilter_sel)
  );

  scch_host i_host (
    .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .cts_n_pin(cts_n_pin)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic replies(input int nr, input int stall, input logic [39:0] e);
    logic [7:0] b;
    for (int i = nr - 1; i >= 0; i--) begin
      i_host.recv_byte(stall, b);
      check("reply byte", {24'h0, b}, {24'h0, e[8*i+:8]});
    end
  endtask : replies

  // Command byte, then parameters high byte first, then the reply
  task automatic cmd(input logic [7:0] c, input int np, input logic [23:0] p,
                     input int nr, input logic [39:0] e);
    i_host.send_byte(c);
    for (int i = np - 1; i >= 0; i--) i_host.send_byte(p[8*i+:8]);
    replies(nr, 0, e);
    // Settings land after execution, derived outputs one edge later
    repeat (3) @(posedge clk);
    #1;
  endtask : cmd

  task automatic err(input logic [7:0] e);
    cmd(8'h42, 0, 24'h0, 1, {32'h0, e});
  endtask : err

  // Pins pass a synchroniser, so let it settle
  task automatic pins(input logic jp, input logic wb);
    config_jumper = jp;
    write_block_pin = wb;
    repeat (8) @(posedge clk);
    #1;
  endtask : pins

  task automatic frame(input logic [15:0] v, input int n, input logic [39:0] e);
    meas_value = v;
    meas_valid = 1'b1;
    @(posedge clk);
    #1;
    meas_valid = 1'b0;
    replies(n, 3, e);
  endtask : frame

  task automatic stop_test;
    n_mismatch += i_host.n_late;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    #1;
    check("rx_ready in reset", {31'h0, rx_ready}, 32'h0);
    check("rts_n in reset", {31'h0, rts_n}, 32'h1);
    check("flags reset", {24'h0, protocol_flags}, 32'h08);
    check("feature reset", {16'h0, feature_flags}, 32'h0010);
    check("link reset", {28'h0, link_bitrate_code}, 32'h3);
    sys_rst = 1'b0;
    pins(1'b0, 1'b0);
    cmd(8'h80, 1, 24'h0, 0, 40'h0);
    err(8'h73);
    err(8'h73);
    cmd(8'h81, 0, 24'h0, 1, 40'h08);
    cmd(8'h7f, 0, 24'h0, 0, 40'h0);
    err(8'h40);
    pins(1'b1, 1'b0);
    cmd(8'h81, 0, 24'h0, 1, 40'h09);
    cmd(8'h80, 1, 24'h0, 0, 40'h0);
    err(8'ha0);
    check("flags short", {24'h0, protocol_flags}, 32'h00);
    frame(16'h1234, 3, 40'ha51234);
    cmd(8'h80, 1, 24'h08, 0, 40'h0);
    frame(16'h8001, 5, 40'ha6ffff8001);
    cmd(8'h80, 1, 24'h88, 0, 40'h0);
    check("flags handshake", {24'h0, protocol_flags}, 32'h88);
    check("rts_n idle", {31'h0, rts_n}, 32'h0);
    i_host.set_cts_n(1'b1);
    pins(1'b1, 1'b0);
    i_host.send_byte(8'h83);
    i_host.hold_ready(12);
    i_host.set_cts_n(1'b0);
    pins(1'b1, 1'b0);
    replies(1, 0, 40'h03);
    cmd(8'h80, 1, 24'h08, 0, 40'h0);
    cmd(8'h82, 1, 24'h05, 0, 40'h0);
    cmd(8'h83, 0, 24'h0, 1, 40'h05);
    check("link with jumper", {28'h0, link_bitrate_code}, 32'h3);
    cmd(8'h82, 1, 24'h0c, 0, 40'h0);
    err(8'h54);
    cmd(8'h8a, 3, 24'hc17530, 0, 40'h0);
    cmd(8'h82, 1, 24'h00, 0, 40'h0);
    err(8'h58);
    cmd(8'h8a, 3, 24'hcc0064, 0, 40'h0);
    err(8'h54);
    cmd(8'h8a, 3, 24'h030064, 0, 40'h0);
    err(8'h53);
    cmd(8'h8a, 3, 24'hc30064, 0, 40'h0);
    check("avg count", {26'h0, conv_avg_count}, 32'h3);
    check("rate reg", {16'h0, conv_rate}, 32'h0064);
    cmd(8'h8b, 0, 24'h0, 3, 40'hc30064);
    pins(1'b0, 1'b0);
    check("link stored", {28'h0, link_bitrate_code}, 32'h5);
    cmd(8'h82, 1, 24'h04, 0, 40'h0);
    err(8'h73);
    cmd(8'h86, 2, 24'h1234, 0, 40'h0);
    cmd(8'h87, 0, 24'h0, 2, 40'h1234);
    cmd(8'h86, 2, 24'h0000, 0, 40'h0);
    err(8'h55);
    cmd(8'h88, 2, 24'h0714, 0, 40'h0);
    cmd(8'h89, 0, 24'h0, 2, 40'h0716);
    cmd(8'h8a, 3, 24'hc10500, 0, 40'h0);
    check("feature avg", {16'h0, feature_flags}, 32'h0714);
    check("prefilter fir", {30'h0, prefilter_sel}, 32'h1);
    cmd(8'h88, 2, 24'h0710, 0, 40'h0);
    check("prefilter", {30'h0, prefilter_sel}, 32'h2);
    max_mode = 1'b1;
    frame(16'hfff0, 5, 40'ha600000010);
    frame(16'h0005, 5, 40'ha600000010);
    max_mode = 1'b0;
    cmd(8'h46, 0, 24'h0, 0, 40'h0);
    err(8'ha1);
    check("norm pulses", n_norm, 32'h1);
    pins(1'b0, 1'b1);
    cmd(8'h86, 2, 24'h0005, 0, 40'h0);
    err(8'h71);
    cmd(8'h81, 0, 24'h0, 1, 40'h18);
    stop_test();
  end

  // Whole sequence needs well under a thousand cycles; 50000 is ample
  initial begin
    #1000000;
    n_mismatch++;
    stop_test();
  end
endmodule : scch_top_bench

`default_nettype wire
